//--- design/rprsc_axil_slave.sv
// AXI4-Lite slave for the port registers: one write and one read at a time.
// Assumes the core answers reads combinationally through the register carrier.
`timescale 1ns/1ns
module rprsc_axil_slave
   import rprsc_pkg::*;
(
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic              awvalid,
   input  wire logic [ADDR_W-1:0] awaddr,
   output logic                   awready,
   input  wire logic              wvalid,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   output logic                   wready,
   output logic                   bvalid,
   output logic [1:0]             bresp,
   input  wire logic              bready,
   input  wire logic              arvalid,
   input  wire logic [ADDR_W-1:0] araddr,
   output logic                   arready,
   output logic                   rvalid,
   output logic [31:0]            rdata,
   output logic [1:0]             rresp,
   input  wire logic              rready,
   rprsc_reg_if.slave             regs
);
   logic              aw_held_r;
   logic              w_held_r;
   logic [ADDR_W-1:0] awaddr_r;
   logic              fire;
   logic              aw_hs;
   logic              w_hs;
   logic              ar_hs;
   logic              rvalid_nxt;

   assign aw_hs      = awvalid && awready;
   assign w_hs       = wvalid && wready;
   assign ar_hs      = arvalid && arready;
   // Response must be free before a write is applied
   assign fire       = aw_held_r && w_held_r && !bvalid;
   assign rvalid_nxt = ar_hs || (rvalid && !rready);

   assign regs.wr_en     = fire;
   assign regs.wr_sel_ps = (awaddr_r[ADDR_W-1:2] == PORT_SC_OFF[ADDR_W-1:2]);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_r <= 1'b0;
         awaddr_r  <= '0;
         awready   <= 1'b0;
      end else begin
         if (aw_hs) begin
            aw_held_r <= 1'b1;
            awaddr_r  <= awaddr;
         end else if (fire) begin
            aw_held_r <= 1'b0;
         end
         awready <= !(aw_held_r ? !fire : aw_hs);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held_r     <= 1'b0;
         regs.wr_data <= '0;
         regs.wr_strb <= '0;
         wready       <= 1'b0;
      end else begin
         if (w_hs) begin
            w_held_r     <= 1'b1;
            regs.wr_data <= wdata;
            regs.wr_strb <= wstrb;
         end else if (fire) begin
            w_held_r <= 1'b0;
         end
         wready <= !(w_held_r ? !fire : w_hs);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp  <= AXI_OKAY;
      end else if (fire) begin
         bvalid <= 1'b1;
         // Status is read-only; writes to it are accepted and dropped
         if (regs.wr_sel_ps || (awaddr_r[ADDR_W-1:2] == USB_STS_OFF[ADDR_W-1:2])) begin
            bresp <= AXI_OKAY;
         end else begin
            bresp <= AXI_SLVERR;
         end
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid  <= 1'b0;
         rdata   <= '0;
         rresp   <= AXI_OKAY;
         arready <= 1'b0;
      end else begin
         rvalid  <= rvalid_nxt;
         arready <= !rvalid_nxt;
         if (ar_hs) begin
            if (araddr[ADDR_W-1:2] == PORT_SC_OFF[ADDR_W-1:2]) begin
               rdata <= regs.rd_ps;
               rresp <= AXI_OKAY;
            end else if (araddr[ADDR_W-1:2] == USB_STS_OFF[ADDR_W-1:2]) begin
               rdata <= regs.rd_sts;
               rresp <= AXI_OKAY;
            end else begin
               rdata <= '0;
               rresp <= AXI_SLVERR;
            end
         end
      end
   end
endmodule // rprsc_axil_slave

//--- design/rprsc_pkg.sv
// Shared constants of the root port reset and suspend control block.
// Assumes a 125 MHz core clock and an AXI4-Lite register bus with 8 address bits.
package rprsc_pkg;
   localparam int          ADDR_W            = 8;
   localparam logic [7:0]  PORT_SC_OFF       = 8'h00;
   localparam logic [7:0]  USB_STS_OFF       = 8'h04;

   // Port status and control fields
   localparam int          ENB_BIT           = 2;
   localparam int          RSM_BIT           = 6;
   localparam int          SPND_BIT          = 7;
   localparam int          RSTB_BIT          = 8;
   // Usb status register fields
   localparam int          HALT_BIT          = 12;

   localparam logic        RSTB_RST          = 1'b0;
   localparam logic        SPND_RST          = 1'b0;
   localparam logic        RSM_RST           = 1'b0;
   localparam logic        ENB_RST           = 1'b0;

   localparam logic [1:0]  AXI_OKAY          = 2'h0;
   localparam logic [1:0]  AXI_SLVERR        = 2'h2;

   localparam logic [1:0]  PST_DISABLED      = 2'h0;
   localparam logic [1:0]  PST_ENABLED       = 2'h1;
   localparam logic [1:0]  PST_SUSPENDED     = 2'h3;

   localparam int          CLK_PERIOD_NS     = 8;
   localparam int          RESET_TAIL_NS     = 10000;
   localparam int          RESUME_TAIL_NS    = 10000;
   localparam int          RESET_DONE_MAX_NS = 2000000;
   // Least times round up, the longest time rounds down
   localparam int          RESET_TAIL_CYC    = (RESET_TAIL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          RESUME_TAIL_CYC   = (RESUME_TAIL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          RESET_DONE_MAX_CYC = RESET_DONE_MAX_NS / CLK_PERIOD_NS;
   localparam int          TMR_W             = 16;

   typedef enum logic [2:0] {
      ST_DISABLED, ST_RESET, ST_RESET_END, ST_ENABLED, ST_SPND_PEND, ST_SUSPENDED, ST_RESUME_END
   } rprsc_state_t;
endpackage

//--- design/rprsc_reg_if.sv
// Register access carrier between the bus slave and the port core.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface rprsc_reg_if;
   logic        wr_en;
   logic        wr_sel_ps;
   logic [31:0] wr_data;
   logic [3:0]  wr_strb;
   logic [31:0] rd_ps;
   logic [31:0] rd_sts;
   modport slave (output wr_en, output wr_sel_ps, output wr_data, output wr_strb, input rd_ps, input rd_sts);
   modport core  (input wr_en, input wr_sel_ps, input wr_data, input wr_strb, output rd_ps, output rd_sts);
endinterface

//--- design/rprsc_timer.sv
// Down counter for the reset and resume tails.
// Assumes load is a one-cycle request; done is high in the last counted cycle.
`timescale 1ns/1ns
module rprsc_timer
   import rprsc_pkg::*;
(
   input  wire logic             aclk,
   input  wire logic             aresetn,
   input  wire logic             load,
   input  wire logic [TMR_W-1:0] load_val,
   output logic                  done
);
   logic [TMR_W-1:0] cnt_r;
   logic             busy_r;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_r  <= '0;
         busy_r <= 1'b0;
      end else if (load) begin
         cnt_r  <= load_val - TMR_W'(1);
         busy_r <= 1'b1;
      end else if (busy_r) begin
         if (cnt_r == '0) begin
            busy_r <= 1'b0;
         end else begin
            cnt_r <= cnt_r - TMR_W'(1);
         end
      end
   end

   assign done = busy_r && (cnt_r == '0);
endmodule // rprsc_timer

//--- design/rprsc_top.sv
// Root hub port reset and suspend control, with its AXI4-Lite register slave.
// Assumes the scheduler's txn_active and the halted flag are on aclk; PHY status pins are asynchronous.
// Functional notes
// - Reset bit shows in-reset, zero after reset
// - Setting reset bit starts bus reset
// - Reset bit reads one until reset finishes
// - High-speed device enables port after reset
// - Reset ends within two milliseconds of clear
// - Reset may stay asserted while halted
// - Suspend resets zero; enabled/suspend give state
// - Suspended port passes no downstream data
// - Running transaction finishes before suspend blocks
// - Suspend bit set only once truly suspended
// - Suspended port watches for resume signalling
// - Software writes of zero to suspend ignored
// - Resume clear or reset set clears suspend
//
// Our own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ns
module rprsc_top
   import rprsc_pkg::*;
#(
   parameter int RESET_DONE_MAX = RESET_DONE_MAX_CYC
) (
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic              s_axi_awvalid,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   output logic                   s_axi_awready,
   input  wire logic              s_axi_wvalid,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   output logic                   s_axi_wready,
   output logic                   s_axi_bvalid,
   output logic [1:0]             s_axi_bresp,
   input  wire logic              s_axi_bready,
   input  wire logic              s_axi_arvalid,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   output logic                   s_axi_arready,
   output logic                   s_axi_rvalid,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   input  wire logic              s_axi_rready,
   input  wire logic              controller_halted_flag,
   input  wire logic              txn_active,
   input  wire logic              hs_detect_pin,
   input  wire logic              resume_k_pin,
   output logic                   bus_reset_drive_r,
   output logic                   resume_drive_r,
   output logic                   port_tx_allow_r,
   output logic [1:0]             port_state_r
);
   rprsc_reg_if rif ();

   rprsc_axil_slave u_slave (
      .aclk    (aclk),
      .aresetn (aresetn),
      .awvalid (s_axi_awvalid),
      .awaddr  (s_axi_awaddr),
      .awready (s_axi_awready),
      .wvalid  (s_axi_wvalid),
      .wdata   (s_axi_wdata),
      .wstrb   (s_axi_wstrb),
      .wready  (s_axi_wready),
      .bvalid  (s_axi_bvalid),
      .bresp   (s_axi_bresp),
      .bready  (s_axi_bready),
      .arvalid (s_axi_arvalid),
      .araddr  (s_axi_araddr),
      .arready (s_axi_arready),
      .rvalid  (s_axi_rvalid),
      .rdata   (s_axi_rdata),
      .rresp   (s_axi_rresp),
      .rready  (s_axi_rready),
      .regs    (rif)
   );

   rprsc_state_t     state_r;
   rprsc_state_t     state_nxt;
   logic             rstb_r;
   logic             rstb_nxt;
   logic             spnd_r;
   logic             spnd_nxt;
   logic             rsm_r;
   logic             rsm_nxt;
   logic             enb_r;
   logic             enb_nxt;
   logic             pend_r;
   logic             pend_nxt;
   logic             hs_seen_r;
   logic [1:0]       sync1_r;
   logic [1:0]       sync2_r;
   logic             hs_sync;
   logic             resume_sync;
   logic             tmr_load;
   logic             tmr_done;
   logic [TMR_W-1:0] tmr_val;
   logic             lane0;
   logic             lane1;
   logic             sw_rstb_set;
   logic             sw_rstb_clr;
   logic             sw_spnd_set;
   logic             sw_rsm_set;
   logic             sw_rsm_clr;
   logic             sw_enb_clr;

   // Asynchronous PHY status: second stage is the only reader of the first
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync1_r <= 2'h0;
         sync2_r <= 2'h0;
      end else begin
         sync1_r <= {resume_k_pin, hs_detect_pin};
         sync2_r <= sync1_r;
      end
   end
   assign hs_sync     = sync2_r[0];
   assign resume_sync = sync2_r[1];

   // Field writes only count when their byte lane is strobed
   assign lane0       = rif.wr_en && rif.wr_sel_ps && rif.wr_strb[0];
   assign lane1       = rif.wr_en && rif.wr_sel_ps && rif.wr_strb[1];
   assign sw_rstb_set = lane1 && rif.wr_data[RSTB_BIT] && !rstb_r;
   assign sw_rstb_clr = lane1 && !rif.wr_data[RSTB_BIT] && rstb_r;
   assign sw_spnd_set = lane0 && rif.wr_data[SPND_BIT] && !spnd_r;
   assign sw_rsm_set  = lane0 && rif.wr_data[RSM_BIT] && !rsm_r;
   assign sw_rsm_clr  = lane0 && !rif.wr_data[RSM_BIT] && rsm_r;
   // Enabled bit can only be cleared by software, never set
   assign sw_enb_clr  = lane0 && !rif.wr_data[ENB_BIT];

   assign tmr_val = (state_r == ST_SUSPENDED) ? TMR_W'(RESUME_TAIL_CYC) : TMR_W'(RESET_TAIL_CYC);

   rprsc_timer u_timer (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .load     (tmr_load),
      .load_val (tmr_val),
      .done     (tmr_done)
   );

   always_comb begin
      state_nxt = state_r;
      rstb_nxt  = rstb_r;
      enb_nxt   = enb_r;
      spnd_nxt  = spnd_r;
      rsm_nxt   = rsm_r;
      pend_nxt  = pend_r;
      tmr_load  = 1'b0;
      if (sw_rstb_set) begin
         state_nxt = ST_RESET;
         rstb_nxt  = 1'b1;
         enb_nxt   = 1'b0;
         spnd_nxt  = 1'b0;
         rsm_nxt   = 1'b0;
         pend_nxt  = 1'b0;
      end else begin
         case (state_r)
            ST_RESET: begin
               if (sw_rstb_clr) begin
                  pend_nxt = 1'b1;
               end
               // A halted controller keeps the port in reset until it runs again
               if ((pend_r || sw_rstb_clr) && !controller_halted_flag) begin
                  state_nxt = ST_RESET_END;
                  tmr_load  = 1'b1;
                  pend_nxt  = 1'b0;
               end
            end
            ST_RESET_END: begin
               if (tmr_done) begin
                  rstb_nxt  = 1'b0;
                  enb_nxt   = hs_seen_r;
                  state_nxt = hs_seen_r ? ST_ENABLED : ST_DISABLED;
               end
            end
            ST_ENABLED: begin
               if (sw_enb_clr) begin
                  enb_nxt   = 1'b0;
                  state_nxt = ST_DISABLED;
               end else if (sw_spnd_set) begin
                  if (txn_active) begin
                     state_nxt = ST_SPND_PEND;
                  end else begin
                     state_nxt = ST_SUSPENDED;
                     spnd_nxt  = 1'b1;
                  end
               end
            end
            ST_SPND_PEND: begin
               if (sw_enb_clr) begin
                  enb_nxt   = 1'b0;
                  state_nxt = ST_DISABLED;
               end else if (!txn_active) begin
                  state_nxt = ST_SUSPENDED;
                  spnd_nxt  = 1'b1;
               end
            end
            ST_SUSPENDED: begin
               if (sw_enb_clr) begin
                  enb_nxt   = 1'b0;
                  spnd_nxt  = 1'b0;
                  rsm_nxt   = 1'b0;
                  state_nxt = ST_DISABLED;
               end else if (sw_rsm_clr) begin
                  spnd_nxt  = 1'b0;
                  state_nxt = ST_RESUME_END;
                  tmr_load  = 1'b1;
               end else if (!rsm_r && (sw_rsm_set || resume_sync)) begin
                  rsm_nxt = 1'b1;
               end
            end
            ST_RESUME_END: begin
               if (tmr_done) begin
                  rsm_nxt   = 1'b0;
                  state_nxt = ST_ENABLED;
               end
            end
            default: begin
               state_nxt = state_r;
            end
         endcase
      end
   end

   // Suspend is never cleared by a software zero, only by the paths above
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_r <= ST_DISABLED;
         rstb_r  <= RSTB_RST;
         spnd_r  <= SPND_RST;
         rsm_r   <= RSM_RST;
         enb_r   <= ENB_RST;
         pend_r  <= 1'b0;
      end else begin
         state_r <= state_nxt;
         rstb_r  <= rstb_nxt;
         spnd_r  <= spnd_nxt;
         rsm_r   <= rsm_nxt;
         enb_r   <= enb_nxt;
         pend_r  <= pend_nxt;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hs_seen_r <= 1'b0;
      end else if (sw_rstb_set) begin
         hs_seen_r <= 1'b0;
      end else if ((state_r == ST_RESET) && hs_sync) begin
         hs_seen_r <= 1'b1;
      end
   end

   // Port reset and resume signalling are the only things a suspended port still sends
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bus_reset_drive_r <= 1'b0;
         resume_drive_r    <= 1'b0;
         port_tx_allow_r   <= 1'b0;
         port_state_r      <= PST_DISABLED;
      end else begin
         bus_reset_drive_r <= (state_nxt == ST_RESET);
         resume_drive_r    <= (state_nxt == ST_SUSPENDED) && rsm_nxt;
         port_tx_allow_r   <= (state_nxt == ST_ENABLED) || (state_nxt == ST_SPND_PEND);
         port_state_r      <= !enb_nxt ? PST_DISABLED : (spnd_nxt ? PST_SUSPENDED : PST_ENABLED);
      end
   end

   always_comb begin
      rif.rd_ps           = 32'h0000_0000;
      rif.rd_ps[RSTB_BIT] = rstb_r;
      rif.rd_ps[SPND_BIT] = spnd_r;
      rif.rd_ps[RSM_BIT]  = rsm_r;
      rif.rd_ps[ENB_BIT]  = enb_r;
      rif.rd_sts          = 32'h0000_0000;
      rif.rd_sts[HALT_BIT] = controller_halted_flag;
   end

   // Helper: cycles spent finishing a reset after software cleared it
   logic [31:0] end_wait_r;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         end_wait_r <= 32'h0000_0000;
      end else if (state_r == ST_RESET_END) begin
         end_wait_r <= end_wait_r + 32'h0000_0001;
      end else begin
         end_wait_r <= 32'h0000_0000;
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_rstb_reads_reset;
      rstb_r == ((state_r == ST_RESET) || (state_r == ST_RESET_END));
   endproperty
   a_rstb_reads_reset: assert property (p_rstb_reads_reset) else $error("reset bit disagrees with port state");

   property p_reset_start;
      sw_rstb_set |=> rstb_r && bus_reset_drive_r && !enb_r;
   endproperty
   a_reset_start: assert property (p_reset_start) else $error("bus reset did not start");

   property p_rstb_holds_after_clear;
      (state_r == ST_RESET) && sw_rstb_clr && !controller_halted_flag |=> rstb_r [*2];
   endproperty
   a_rstb_holds_after_clear: assert property (p_rstb_holds_after_clear) else $error("reset bit dropped early");

   property p_hs_enable;
      (state_r == ST_RESET_END) && tmr_done && hs_seen_r |=> enb_r && !rstb_r && port_state_r == PST_ENABLED;
   endproperty
   a_hs_enable: assert property (p_hs_enable) else $error("high-speed port not enabled");

   property p_reset_bound;
      end_wait_r <= 32'(RESET_DONE_MAX);
   endproperty
   a_reset_bound: assert property (p_reset_bound) else $error("reset end took too long");

   property p_halt_holds;
      (state_r == ST_RESET) && controller_halted_flag && !sw_rstb_set |=> rstb_r && (state_r == ST_RESET);
   endproperty
   a_halt_holds: assert property (p_halt_holds) else $error("reset released while halted");

   property p_spnd_needs_enb;
      spnd_r |-> enb_r;
   endproperty
   a_spnd_needs_enb: assert property (p_spnd_needs_enb) else $error("suspended without enabled");

   property p_no_tx_suspended;
      spnd_r |-> !port_tx_allow_r;
   endproperty
   a_no_tx_suspended: assert property (p_no_tx_suspended) else $error("traffic passed while suspended");

   property p_finish_then_block;
      (state_r == ST_SPND_PEND) && txn_active && !sw_enb_clr && !sw_rstb_set |=> !spnd_r && port_tx_allow_r;
   endproperty
   a_finish_then_block: assert property (p_finish_then_block) else $error("blocked during transaction");

   property p_spnd_set_idle;
      $rose(spnd_r) |-> !$past(txn_active);
   endproperty
   a_spnd_set_idle: assert property (p_spnd_set_idle) else $error("suspend bit set during transaction");

   property p_resume_seen;
      (state_r == ST_SUSPENDED) && resume_sync && !rsm_r && !sw_enb_clr && !sw_rstb_set |=> rsm_r && resume_drive_r;
   endproperty
   a_resume_seen: assert property (p_resume_seen) else $error("resume not detected");

   property p_spnd_zero_ignored;
      spnd_r && lane0 && !rif.wr_data[SPND_BIT] && !sw_enb_clr && !sw_rsm_clr && !sw_rstb_set |=> spnd_r;
   endproperty
   a_spnd_zero_ignored: assert property (p_spnd_zero_ignored) else $error("software cleared suspend");

   property p_spnd_cleared;
      sw_rstb_set || ((state_r == ST_SUSPENDED) && sw_rsm_clr) |=> !spnd_r;
   endproperty
   a_spnd_cleared: assert property (p_spnd_cleared) else $error("suspend not cleared");

   c_hs_reset:  cover property ((state_r == ST_RESET_END) ##1 (state_r == ST_ENABLED));
   c_spnd_wait: cover property ((state_r == ST_SPND_PEND) ##1 (state_r == ST_SUSPENDED));
   c_resume:    cover property ((state_r == ST_RESUME_END) ##1 (state_r == ST_ENABLED));
   c_fs_reset:  cover property ((state_r == ST_RESET_END) ##1 (state_r == ST_DISABLED));
endmodule // rprsc_top

//--- verification/root_port_reset_suspend_control_tb.sv
// Bench for the port reset and suspend block, driven over AXI4-Lite.
// Assumes the device model on the port pins and the package constants.
`timescale 1ns/1ns
module root_port_reset_suspend_control_tb
   import rprsc_pkg::*;
;
   logic aclk = 1'b0, aresetn = 1'b0, awv = 1'b0, wv = 1'b0, brdy = 1'b0, arv = 1'b0, rrdy = 1'b0;
   logic halt = 1'b0, txn = 1'b0, wake = 1'b0;
   logic [7:0] awa = 8'h00, ara = 8'h00;
   logic [31:0] wd = 32'h0000_0000, rdt, d;
   logic awr, wr_rdy, bv, arr, rv, bdrv, rdrv, txok, hs, rk;
   logic [1:0] bresp, rresp, pst, r;
   int failures = 0, check_count = 0, cyc = 0;
   localparam logic [31:0] PRM = 32'h0000_0001 << RSTB_BIT, SPM = 32'h0000_0001 << SPND_BIT;
   localparam logic [31:0] FPM = 32'h0000_0001 << RSM_BIT, PEM = 32'h0000_0001 << ENB_BIT;
   localparam logic [31:0] MSK = PRM | SPM | FPM | PEM;
   rprsc_top i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awv), .s_axi_awaddr(awa),
      .s_axi_awready(awr), .s_axi_wvalid(wv), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wready(wr_rdy),
      .s_axi_bvalid(bv), .s_axi_bresp(bresp), .s_axi_bready(brdy), .s_axi_arvalid(arv), .s_axi_araddr(ara),
      .s_axi_arready(arr), .s_axi_rvalid(rv), .s_axi_rdata(rdt), .s_axi_rresp(rresp), .s_axi_rready(rrdy),
      .controller_halted_flag(halt), .txn_active(txn), .hs_detect_pin(hs), .resume_k_pin(rk),
      .bus_reset_drive_r(bdrv), .resume_drive_r(rdrv), .port_tx_allow_r(txok), .port_state_r(pst));
   rprsc_usb_dev_model i_dev (.aclk(aclk), .bus_reset_drive_r(bdrv), .resume_drive_r(rdrv),
      .wake_req(wake), .hs_detect_pin(hs), .resume_k_pin(rk));
   initial forever #4 aclk = ~aclk;
   task automatic wrap_up();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Valid and payload are held until the edge that samples ready
   // Waits are ended only by the bench timeout
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge aclk);
      awv <= 1'b1;
      wv <= 1'b1;
      awa <= a;
      wd <= v;
      brdy <= 1'b1;
      do begin
         @(posedge aclk);
         if (awr === 1'b1) awv <= 1'b0;
         if (wr_rdy === 1'b1) wv <= 1'b0;
      end while (bv !== 1'b1);
      brdy <= 1'b0;
      chk("bresp", 32'(AXI_OKAY), 32'(bresp));
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      arv <= 1'b1;
      ara <= a;
      rrdy <= 1'b1;
      do begin
         @(posedge aclk);
         if (arr === 1'b1) arv <= 1'b0;
      end while (rv !== 1'b1);
      rrdy <= 1'b0;
      d = rdt;
      r = rresp;
   endtask
   task automatic rchk(input string nm, input logic [31:0] e);
      rd(PORT_SC_OFF);
      chk(nm, e, d & MSK);
   endtask
   // Bounded poll; the bound is far inside the two millisecond limit
   task automatic poll(input logic [31:0] m, input logic [31:0] v);
      int n = 0;
      do begin
         rd(PORT_SC_OFF);
         n++;
      end while ((d & m) !== v && n < 600);
      chk("poll", v, d & m);
   endtask
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         failures++;
         wrap_up();
      end
   end
   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      rchk("ps_rst", 32'h0000_0000);
      chk("st_rst", 32'(PST_DISABLED), 32'(pst));
      wr(PORT_SC_OFF, PRM);
      chk("bdrv", 32'h0000_0001, 32'(bdrv));
      repeat (6) @(posedge aclk);
      wr(PORT_SC_OFF, 32'h0000_0000);
      rchk("rstb_hold", PRM);
      poll(PRM, 32'h0000_0000);
      rchk("hs_en", PEM);
      chk("st_en", 32'(PST_ENABLED), 32'(pst));
      txn <= 1'b1;
      wr(PORT_SC_OFF, PEM | SPM);
      rchk("spnd_wait", PEM);
      chk("tx_busy", 32'h0000_0001, 32'(txok));
      txn <= 1'b0;
      repeat (3) @(posedge aclk);
      rchk("spnd_on", PEM | SPM);
      chk("tx_blk", 32'h0000_0000, 32'(txok));
      chk("st_sus", 32'(PST_SUSPENDED), 32'(pst));
      wr(PORT_SC_OFF, PEM);
      rchk("spnd_keep", PEM | SPM);
      wake <= 1'b1;
      repeat (8) @(posedge aclk);
      wake <= 1'b0;
      rchk("rsm_on", PEM | SPM | FPM);
      chk("rdrv_on", 32'h0000_0001, 32'(rdrv));
      wr(PORT_SC_OFF, PEM);
      rchk("spnd_clr", PEM | FPM);
      chk("rdrv_off", 32'h0000_0000, 32'(rdrv));
      poll(FPM, 32'h0000_0000);
      chk("st_res", 32'(PST_ENABLED), 32'(pst));
      wr(PORT_SC_OFF, PEM | SPM);
      rchk("spnd_idle", PEM | SPM);
      wr(PORT_SC_OFF, PRM);
      rchk("spnd_rst", PRM);
      halt <= 1'b1;
      wr(PORT_SC_OFF, 32'h0000_0000);
      repeat (1300) @(posedge aclk);
      rchk("rstb_halt", PRM);
      rd(USB_STS_OFF);
      chk("sts_halt", 32'h0000_0001 << HALT_BIT, d & (32'h0000_0001 << HALT_BIT));
      halt <= 1'b0;
      poll(PRM, 32'h0000_0000);
      rchk("hs_en2", PEM);
      wr(PORT_SC_OFF, 32'h0000_0000);
      chk("st_dis", 32'(PST_DISABLED), 32'(pst));
      rd(8'h10);
      chk("unmap_resp", 32'(AXI_SLVERR), 32'(r));
      chk("unmap_data", 32'h0000_0000, d);
      wrap_up();
   end
endmodule // root_port_reset_suspend_control_tb

//--- verification/rprsc_usb_dev_model.sv
// Behavioural high-speed device on the root port pins.
// Assumes the host drives reset and resume as registered levels on aclk.
`timescale 1ns/1ns
module rprsc_usb_dev_model (
   input  wire logic aclk,
   input  wire logic bus_reset_drive_r,
   input  wire logic resume_drive_r,
   input  wire logic wake_req,
   output logic      hs_detect_pin,
   output logic      resume_k_pin
);
   // Chirps only while SE0 is driven, so a chirp after reset is never seen
   always_ff @(posedge aclk) begin
      hs_detect_pin <= bus_reset_drive_r;
   end
   // Remote wake K is dropped once the host drives its own resume
   always_ff @(posedge aclk) begin
      resume_k_pin <= wake_req & ~resume_drive_r;
   end
endmodule // rprsc_usb_dev_model
